/* src/sdm_pkg.sv */
// Constants for the servo drive digital input and output function map.
// Assumes a 125 MHz system clock and a 32-bit classic Wishbone register port.
package sdm_pkg;

	// Clock and timing.
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned TICK_HZ = 1000;
	localparam int unsigned TICK_CYCLES = CLK_HZ / TICK_HZ;

	// Pin counts and code widths.
	localparam int unsigned DI_PINS = 8;
	localparam int unsigned DO_PINS = 5;
	localparam int unsigned CODE_W = 6;
	localparam int unsigned NCODES = 64;
	localparam int unsigned FAULTS = 8;
	localparam int unsigned WARN_FAULTS = 5;

	// Register byte offsets.
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DI_MAP0 = 8'h04;
	localparam logic [7:0] OFS_DI_MAP1 = 8'h08;
	localparam logic [7:0] OFS_DO_MAP = 8'h0C;
	localparam logic [7:0] OFS_POLARITY = 8'h10;
	localparam logic [7:0] OFS_THRESH = 8'h14;
	localparam logic [7:0] OFS_CMD_DELAY = 8'h18;
	localparam logic [7:0] OFS_CLR_MASK = 8'h1C;
	localparam logic [7:0] OFS_STATUS = 8'h20;
	localparam logic [7:0] OFS_FAULTS = 8'h24;

	// Reset values.
	localparam logic [31:0] RST_CTRL = 32'h0000_0000;
	localparam logic [31:0] RST_DI_MAP0 = 32'h0805_0402;
	localparam logic [31:0] RST_DI_MAP1 = 32'h0E0D_0C0B;
	localparam logic [31:0] RST_DI_MAP0_PIN0 = 32'h0000_0001;
	localparam logic [31:0] RST_DO_MAP = 32'h0C2C_7144;
	localparam logic [31:0] RST_POLARITY = 32'h0000_0000;
	localparam logic [31:0] RST_THRESH = 32'h0064_000A;
	localparam logic [31:0] RST_CMD_DELAY = 32'h0000_0000;
	localparam logic [31:0] RST_CLR_MASK = 32'h0000_00FF;

	// Field positions.
	localparam int unsigned CTRL_MODE_LSB = 0;
	localparam int unsigned CTRL_PCLR_LSB = 4;
	localparam int unsigned POL_DO_LSB = 16;
	localparam int unsigned THR_OL_LSB = 16;

	// Control modes.
	localparam logic [3:0] MODE_PT = 4'h0;
	localparam logic [3:0] MODE_PR = 4'h1;
	localparam logic [3:0] MODE_S = 4'h2;
	localparam logic [3:0] MODE_T = 4'h3;
	localparam logic [3:0] MODE_SZ = 4'h4;
	localparam logic [3:0] MODE_TZ = 4'h5;
	localparam logic [3:0] MODE_PT_S = 4'h6;
	localparam logic [3:0] MODE_PT_T = 4'h7;
	localparam logic [3:0] MODE_PR_S = 4'h8;
	localparam logic [3:0] MODE_PR_T = 4'h9;
	localparam logic [3:0] MODE_S_T = 4'hA;

	// Input function codes.
	localparam logic [5:0] DI_SERVO_ON = 6'h01;
	localparam logic [5:0] DI_ALARM_RESET = 6'h02;
	localparam logic [5:0] DI_PULSE_CLEAR = 6'h04;
	localparam logic [5:0] DI_ZERO_CLAMP = 6'h05;
	localparam logic [5:0] DI_CMD_INVERT = 6'h06;
	localparam logic [5:0] DI_HOLD = 6'h07;
	localparam logic [5:0] DI_CMD_TRIGGER = 6'h08;
	localparam logic [5:0] DI_TORQUE_LIM = 6'h09;
	localparam logic [5:0] DI_SPEED_LIM = 6'h0A;
	localparam logic [5:0] DI_POS_SEL0 = 6'h0B;
	localparam logic [5:0] DI_POS_SEL1 = 6'h0C;
	localparam logic [5:0] DI_POS_SEL2 = 6'h0D;
	localparam logic [5:0] DI_SPEED_SEL0 = 6'h0E;
	localparam logic [5:0] DI_SPEED_SEL1 = 6'h0F;
	localparam logic [5:0] DI_HOME_SENSOR = 6'h18;

	// Output function codes.
	localparam logic [5:0] DO_SPEED_OR_HOME = 6'h04;
	localparam logic [5:0] DO_INPOS_OR_BRAKE = 6'h05;
	localparam logic [5:0] DO_ALARM = 6'h07;
	localparam logic [5:0] DO_BRAKE = 6'h08;
	localparam logic [5:0] DO_HOME = 6'h09;
	localparam logic [5:0] DO_OVERLOAD = 6'h0A;
	localparam logic [5:0] DO_WARN = 6'h0B;
	localparam logic [5:0] DO_CMD_DONE = 6'h0C;

	// Command-complete sequencer.
	typedef enum logic [3:0] {
		CD_IDLE = 4'b0001,
		CD_MOVE = 4'b0010,
		CD_WAIT = 4'b0100,
		CD_DONE = 4'b1000
	} sdm_cmd_e;

endpackage

/* src/sdm_top.sv */
// Digital input and output function map of a servo drive, with a Wishbone register port.
// Assumes DI_I comes from pins; all other drive-side inputs are on CLK_I.
`timescale 1ns/10ps

module sdm_top #(
	parameter int unsigned TICK_CYCLES = sdm_pkg::TICK_CYCLES
) (
	// Clock and reset.
	input wire logic CLK_I,
	input wire logic RST_I,
	// Wishbone slave.
	input wire logic [7:0] ADR_I,
	input wire logic [31:0] DAT_I,
	input wire logic [3:0] SEL_I,
	input wire logic WE_I,
	input wire logic CYC_I,
	input wire logic STB_I,
	output logic [31:0] DAT_O,
	output logic ACK_O,
	// Digital pins.
	input wire logic [7:0] DI_I,
	output logic [4:0] DO_O,
	// Drive state.
	input wire logic [7:0] FAULT_I,
	input wire logic BRAKE_REQ_I,
	input wire logic HOME_COND_I,
	input wire logic TARGET_SPEED_I,
	input wire logic IN_POSITION_I,
	input wire logic [15:0] MOTOR_SPEED_I,
	input wire logic [7:0] MOTOR_LOAD_I,
	input wire logic MOVE_DONE_I,
	// Drive commands.
	output logic SERVO_READY_O,
	output logic POS_CLEAR_O,
	output logic [1:0] POS_CLEAR_MODE_O,
	output logic ZERO_HOLD_O,
	output logic DIR_INVERT_O,
	output logic MOVE_HOLD_O,
	output logic MOVE_START_O,
	output logic [2:0] MOVE_INDEX_O,
	output logic TORQUE_LIMIT_EN_O,
	output logic SPEED_LIMIT_EN_O,
	output logic [1:0] SPEED_SRC_O
);

	////////////////////////////////////////////////////////////////////////////////
	// Register bus.

	logic [31:0] ctrl_reg, di_map0_reg, di_map1_reg, do_map_reg, polarity_reg;
	logic [31:0] thresh_reg, cmd_delay_reg, clr_mask_reg;
	logic [31:0] dat_reg;
	logic ack_reg;
	logic [31:0] status_word;
	logic [7:0] fault_reg;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdat,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = wdat[b*8 +: 8];
			end
		end
		return res;
	endfunction

	wire bus_req = CYC_I && STB_I && !ack_reg;
	wire bus_wr = bus_req && WE_I;
	wire wr_ctrl = bus_wr && (ADR_I == sdm_pkg::OFS_CTRL);
	wire wr_di0 = bus_wr && (ADR_I == sdm_pkg::OFS_DI_MAP0);
	wire wr_di1 = bus_wr && (ADR_I == sdm_pkg::OFS_DI_MAP1);
	wire wr_do = bus_wr && (ADR_I == sdm_pkg::OFS_DO_MAP);
	wire wr_pol = bus_wr && (ADR_I == sdm_pkg::OFS_POLARITY);
	wire wr_thr = bus_wr && (ADR_I == sdm_pkg::OFS_THRESH);
	wire wr_dly = bus_wr && (ADR_I == sdm_pkg::OFS_CMD_DELAY);
	wire wr_msk = bus_wr && (ADR_I == sdm_pkg::OFS_CLR_MASK);

	// Unmapped addresses are acknowledged, read as zero and ignore writes.
	wire [31:0] rd_mux =
		(ADR_I == sdm_pkg::OFS_CTRL) ? ctrl_reg :
		(ADR_I == sdm_pkg::OFS_DI_MAP0) ? di_map0_reg :
		(ADR_I == sdm_pkg::OFS_DI_MAP1) ? di_map1_reg :
		(ADR_I == sdm_pkg::OFS_DO_MAP) ? do_map_reg :
		(ADR_I == sdm_pkg::OFS_POLARITY) ? polarity_reg :
		(ADR_I == sdm_pkg::OFS_THRESH) ? thresh_reg :
		(ADR_I == sdm_pkg::OFS_CMD_DELAY) ? cmd_delay_reg :
		(ADR_I == sdm_pkg::OFS_CLR_MASK) ? clr_mask_reg :
		(ADR_I == sdm_pkg::OFS_STATUS) ? status_word :
		(ADR_I == sdm_pkg::OFS_FAULTS) ? {24'h00_0000, fault_reg} : 32'h0000_0000;

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= bus_req;
			dat_reg <= bus_req ? rd_mux : 32'h0000_0000;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			ctrl_reg <= sdm_pkg::RST_CTRL;
			di_map0_reg <= {sdm_pkg::RST_DI_MAP0[31:8], sdm_pkg::RST_DI_MAP0_PIN0[7:0]};
			di_map1_reg <= sdm_pkg::RST_DI_MAP1;
			do_map_reg <= sdm_pkg::RST_DO_MAP;
			polarity_reg <= sdm_pkg::RST_POLARITY;
			thresh_reg <= sdm_pkg::RST_THRESH;
			cmd_delay_reg <= sdm_pkg::RST_CMD_DELAY;
			clr_mask_reg <= sdm_pkg::RST_CLR_MASK;
		end else begin
			if (wr_ctrl) ctrl_reg <= merge(ctrl_reg, DAT_I, SEL_I);
			if (wr_di0) di_map0_reg <= merge(di_map0_reg, DAT_I, SEL_I);
			if (wr_di1) di_map1_reg <= merge(di_map1_reg, DAT_I, SEL_I);
			if (wr_do) do_map_reg <= merge(do_map_reg, DAT_I, SEL_I);
			if (wr_pol) polarity_reg <= merge(polarity_reg, DAT_I, SEL_I);
			if (wr_thr) thresh_reg <= merge(thresh_reg, DAT_I, SEL_I);
			if (wr_dly) cmd_delay_reg <= merge(cmd_delay_reg, DAT_I, SEL_I);
			if (wr_msk) clr_mask_reg <= merge(clr_mask_reg, DAT_I, SEL_I);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Input pins: synchronise, apply polarity, route to functions.

	logic [7:0] di_meta_reg, di_sync_reg;

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			di_meta_reg <= 8'h00;
			di_sync_reg <= 8'h00;
		end else begin
			di_meta_reg <= DI_I;
			di_sync_reg <= di_meta_reg;
		end
	end

	wire [7:0] di_level = di_sync_reg ^ polarity_reg[7:0];
	wire [63:0] di_map_all = {di_map1_reg, di_map0_reg};
	logic [63:0] di_func;

	// A function is active when any pin mapped to it is active.
	for (genvar f = 0; f < sdm_pkg::NCODES; f++) begin : g_di_func
		logic [7:0] hit;
		for (genvar p = 0; p < sdm_pkg::DI_PINS; p++) begin : g_pin
			assign hit[p] = di_level[p] && (di_map_all[p*8 +: 6] == 6'(f));
		end
		assign di_func[f] = |hit;
	end

	wire [3:0] mode = ctrl_reg[sdm_pkg::CTRL_MODE_LSB +: 4];
	wire mode_pt = (mode == sdm_pkg::MODE_PT) || (mode == sdm_pkg::MODE_PT_S) ||
		(mode == sdm_pkg::MODE_PT_T);
	wire mode_pr = (mode == sdm_pkg::MODE_PR) || (mode == sdm_pkg::MODE_PR_S) ||
		(mode == sdm_pkg::MODE_PR_T);
	wire mode_speed = (mode == sdm_pkg::MODE_S) || (mode == sdm_pkg::MODE_SZ) ||
		(mode == sdm_pkg::MODE_PT_S) || (mode == sdm_pkg::MODE_PR_S) ||
		(mode == sdm_pkg::MODE_S_T);
	wire mode_torque = (mode == sdm_pkg::MODE_T) || (mode == sdm_pkg::MODE_TZ) ||
		(mode == sdm_pkg::MODE_PT_T) || (mode == sdm_pkg::MODE_PR_T) ||
		(mode == sdm_pkg::MODE_S_T);
	wire mode_pos_only = (mode == sdm_pkg::MODE_PT) || (mode == sdm_pkg::MODE_PR);

	logic alarm_reset_in_d_reg, pclr_d_reg, trig_d_reg;
	wire alarm_reset_in_rise = di_func[sdm_pkg::DI_ALARM_RESET] && !alarm_reset_in_d_reg;
	wire pclr_rise = di_func[sdm_pkg::DI_PULSE_CLEAR] && !pclr_d_reg;
	wire trig_rise = di_func[sdm_pkg::DI_CMD_TRIGGER] && !trig_d_reg;
	wire [2:0] pos_code = {di_func[sdm_pkg::DI_POS_SEL2], di_func[sdm_pkg::DI_POS_SEL1],
		di_func[sdm_pkg::DI_POS_SEL0]};

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			alarm_reset_in_d_reg <= 1'b0;
			pclr_d_reg <= 1'b0;
			trig_d_reg <= 1'b0;
		end else begin
			alarm_reset_in_d_reg <= di_func[sdm_pkg::DI_ALARM_RESET];
			pclr_d_reg <= di_func[sdm_pkg::DI_PULSE_CLEAR];
			trig_d_reg <= di_func[sdm_pkg::DI_CMD_TRIGGER];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Faults, warning and alarm.

	logic [7:0] fault_d_reg;
	logic warn_reg, alarm_reg;

	// Warning-class faults enter the latch from a delayed copy, so warning leads alarm.
	wire [7:0] fault_set = {FAULT_I[7:5], fault_d_reg[4:0]};
	wire [7:0] fault_clr = alarm_reset_in_rise ? clr_mask_reg[7:0] : 8'h00;
	wire [7:0] fault_next = (fault_reg & ~fault_clr) | fault_set;

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			fault_d_reg <= 8'h00;
			fault_reg <= 8'h00;
			warn_reg <= 1'b0;
			alarm_reg <= 1'b0;
		end else begin
			fault_d_reg <= FAULT_I;
			fault_reg <= fault_next;
			warn_reg <= |FAULT_I[4:0];
			alarm_reg <= |fault_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Millisecond tick and command-complete sequencer.

	logic [31:0] tick_cnt_reg;
	logic tick_reg;
	logic [15:0] wait_cnt_reg;
	sdm_pkg::sdm_cmd_e cmd_state_reg, cmd_state_next;

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			tick_cnt_reg <= 32'h0000_0000;
			tick_reg <= 1'b0;
		end else begin
			tick_reg <= (tick_cnt_reg == 32'(TICK_CYCLES - 1));
			tick_cnt_reg <= (tick_cnt_reg == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000 :
				tick_cnt_reg + 32'h0000_0001;
		end
	end

	wire move_start = trig_rise && mode_pr && SERVO_READY_O;
	wire delay_over = (wait_cnt_reg >= cmd_delay_reg[15:0]);

	always_comb begin
		cmd_state_next = cmd_state_reg;
		unique case (cmd_state_reg)
			sdm_pkg::CD_IDLE: begin
				if (move_start) cmd_state_next = sdm_pkg::CD_MOVE;
			end
			sdm_pkg::CD_MOVE: begin
				if (MOVE_DONE_I) cmd_state_next = sdm_pkg::CD_WAIT;
			end
			sdm_pkg::CD_WAIT: begin
				if (move_start) cmd_state_next = sdm_pkg::CD_MOVE;
				else if (delay_over) cmd_state_next = sdm_pkg::CD_DONE;
			end
			sdm_pkg::CD_DONE: begin
				if (move_start) cmd_state_next = sdm_pkg::CD_MOVE;
			end
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			cmd_state_reg <= sdm_pkg::CD_IDLE;
			wait_cnt_reg <= 16'h0000;
		end else begin
			cmd_state_reg <= cmd_state_next;
			if (cmd_state_reg != sdm_pkg::CD_WAIT) wait_cnt_reg <= 16'h0000;
			else if (tick_reg && !delay_over) wait_cnt_reg <= wait_cnt_reg + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output functions and pin routing.

	logic home_reg, overload_reg, done_reg, brake_reg;
	logic [63:0] do_func;

	always_comb begin
		do_func = 64'h0;
		do_func[sdm_pkg::DO_ALARM] = alarm_reg;
		do_func[sdm_pkg::DO_WARN] = warn_reg;
		do_func[sdm_pkg::DO_BRAKE] = brake_reg;
		do_func[sdm_pkg::DO_HOME] = home_reg;
		do_func[sdm_pkg::DO_OVERLOAD] = overload_reg;
		do_func[sdm_pkg::DO_CMD_DONE] = done_reg;
		do_func[sdm_pkg::DO_SPEED_OR_HOME] = mode_pos_only ? home_reg : TARGET_SPEED_I;
		do_func[sdm_pkg::DO_INPOS_OR_BRAKE] = (mode_pt || mode_pr) ? IN_POSITION_I :
			brake_reg;
	end

	logic [4:0] do_pin_reg;
	logic [4:0] do_pin_next;

	for (genvar p = 0; p < sdm_pkg::DO_PINS; p++) begin : g_do_pin
		assign do_pin_next[p] = do_func[do_map_reg[p*6 +: 6]] ^
			polarity_reg[sdm_pkg::POL_DO_LSB + p];
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			home_reg <= 1'b0;
			overload_reg <= 1'b0;
			done_reg <= 1'b0;
			brake_reg <= 1'b0;
			do_pin_reg <= 5'h00;
		end else begin
			home_reg <= di_func[sdm_pkg::DI_HOME_SENSOR] && HOME_COND_I &&
				mode_pos_only;
			overload_reg <= (MOTOR_LOAD_I >= thresh_reg[sdm_pkg::THR_OL_LSB +: 8]);
			done_reg <= (cmd_state_reg == sdm_pkg::CD_DONE);
			brake_reg <= BRAKE_REQ_I;
			do_pin_reg <= do_pin_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Drive commands.

	logic ready_reg, pclr_reg, zhold_reg, inv_reg, hold_reg, start_reg, tlim_reg, slim_reg;
	logic [2:0] index_reg;
	logic [1:0] ssrc_reg;

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			ready_reg <= 1'b0;
			pclr_reg <= 1'b0;
			zhold_reg <= 1'b0;
			inv_reg <= 1'b0;
			hold_reg <= 1'b0;
			start_reg <= 1'b0;
			index_reg <= 3'h0;
			tlim_reg <= 1'b0;
			slim_reg <= 1'b0;
			ssrc_reg <= 2'h0;
		end else begin
			ready_reg <= di_func[sdm_pkg::DI_SERVO_ON] && !(|fault_reg);
			pclr_reg <= pclr_rise && mode_pt;
			zhold_reg <= di_func[sdm_pkg::DI_ZERO_CLAMP] &&
				(MOTOR_SPEED_I < thresh_reg[15:0]);
			inv_reg <= di_func[sdm_pkg::DI_CMD_INVERT];
			hold_reg <= di_func[sdm_pkg::DI_HOLD] && mode_pr;
			start_reg <= move_start;
			if (move_start) index_reg <= pos_code;
			tlim_reg <= di_func[sdm_pkg::DI_TORQUE_LIM] && mode_speed;
			slim_reg <= di_func[sdm_pkg::DI_SPEED_LIM] && mode_torque;
			ssrc_reg <= {di_func[sdm_pkg::DI_SPEED_SEL1], di_func[sdm_pkg::DI_SPEED_SEL0]};
		end
	end

	assign status_word = {15'h0000, cmd_state_reg, ssrc_reg, index_reg, done_reg,
		overload_reg, home_reg, brake_reg, warn_reg, alarm_reg, ready_reg, hold_reg};

	assign DAT_O = dat_reg;
	assign ACK_O = ack_reg;
	assign DO_O = do_pin_reg;
	assign SERVO_READY_O = ready_reg;
	assign POS_CLEAR_O = pclr_reg;
	assign POS_CLEAR_MODE_O = ctrl_reg[sdm_pkg::CTRL_PCLR_LSB +: 2];
	assign ZERO_HOLD_O = zhold_reg;
	assign DIR_INVERT_O = inv_reg;
	assign MOVE_HOLD_O = hold_reg;
	assign MOVE_START_O = start_reg;
	assign MOVE_INDEX_O = index_reg;
	assign TORQUE_LIMIT_EN_O = tlim_reg;
	assign SPEED_LIMIT_EN_O = slim_reg;
	assign SPEED_SRC_O = ssrc_reg;

endmodule

/* verif/sdm_chk_sva.sv */
// Checker for the servo drive function map: bus handshake and drive command pulses.
// Assumes it is bound to sdm_top and sees only that module's ports.
`timescale 1ns/10ps
module sdm_chk (
	// Clock and reset.
	input wire logic CLK_I,
	input wire logic RST_I,
	// Bus.
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic ACK_O,
	input wire logic [31:0] DAT_O,
	// Drive side.
	input wire logic [7:0] FAULT_I,
	input wire logic SERVO_READY_O,
	input wire logic POS_CLEAR_O,
	input wire logic MOVE_START_O,
	input wire logic [2:0] MOVE_INDEX_O
);
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (RST_I);
	////////////////////////////////////////////////////////////////////////////////
	ack_answer_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
		else $error("Request not answered in the next cycle.");
	ack_single_a: assert property (ACK_O |=> !ACK_O)
		else $error("Acknowledge longer than one cycle.");
	ack_cause_a: assert property (ACK_O |-> $past(CYC_I) && $past(STB_I))
		else $error("Acknowledge without a request.");
	data_idle_a: assert property (!ACK_O |-> DAT_O == 32'h0000_0000)
		else $error("Read data not zero outside an acknowledge.");
	ready_fault_a: assert property (FAULT_I != 8'h00 |-> ##[1:6] !SERVO_READY_O)
		else $error("Servo stays ready with a fault present.");
	start_ready_a: assert property (MOVE_START_O |-> SERVO_READY_O || $past(SERVO_READY_O))
		else $error("Move started while servo not ready.");
	start_single_a: assert property (MOVE_START_O |=> !MOVE_START_O)
		else $error("Move start longer than one cycle.");
	clear_single_a: assert property (POS_CLEAR_O |=> !POS_CLEAR_O)
		else $error("Pulse clear longer than one cycle.");
	index_hold_a: assert property (!MOVE_START_O |-> $stable(MOVE_INDEX_O))
		else $error("Move index changed without a start.");
	ack_c: cover property (ACK_O);
	start_c: cover property (MOVE_START_O);
	clear_c: cover property (POS_CLEAR_O);
endmodule

bind sdm_top sdm_chk chk (.CLK_I(CLK_I), .RST_I(RST_I), .CYC_I(CYC_I), .STB_I(STB_I),
	.ACK_O(ACK_O), .DAT_O(DAT_O), .FAULT_I(FAULT_I), .SERVO_READY_O(SERVO_READY_O),
	.POS_CLEAR_O(POS_CLEAR_O), .MOVE_START_O(MOVE_START_O), .MOVE_INDEX_O(MOVE_INDEX_O));

/* verif/sdm_ctrl_model.sv */
// Model of the machine controller that drives the drive's digital input pins.
// Assumes the bench sets the wanted levels in pin order on the system clock.
`timescale 1ns/10ps
module sdm_ctrl_model (
	// Clock.
	input wire logic clk_i,
	// Requests from the bench.
	input wire logic [7:0] level_i,
	input wire logic slow_i,
	// Drive input pins.
	output logic [7:0] pins_o = 8'h00
);
	logic [7:0] stage_reg = 8'h00;

	// A slow controller shows each new pattern one cycle later.
	always @(posedge clk_i) begin
		stage_reg <= level_i;
		pins_o <= slow_i ? stage_reg : level_i;
	end
endmodule

/* verif/testbench.sv */
// Self-checking bench for the servo drive function map.
// Assumes the design package is compiled first; the controller model drives the pins.
`timescale 1ns/10ps
module testbench;
	localparam int unsigned TICKS = 4;
	// One bit per control mode code: speed class, torque class, and shared pin showing brake.
	localparam logic [10:0] spd_modes = 11'h554;
	localparam logic [10:0] trq_modes = 11'h6A8;
	localparam logic [10:0] brk_modes = 11'h43C;
	logic CLK_I = 1'b0;
	logic RST_I = 1'b1;
	logic [7:0] ADR_I = 8'h00;
	logic [31:0] DAT_I = 32'h0;
	logic [3:0] SEL_I = 4'h0;
	logic WE_I = 1'b0, CYC_I = 1'b0, STB_I = 1'b0;
	logic [31:0] DAT_O;
	logic ACK_O;
	logic [7:0] DI_I;
	logic [4:0] DO_O;
	logic [7:0] FAULT_I = 8'h00, MOTOR_LOAD_I = 8'h00;
	logic BRAKE_REQ_I = 1'b0, HOME_COND_I = 1'b0, TARGET_SPEED_I = 1'b0, IN_POSITION_I = 1'b0;
	logic [15:0] MOTOR_SPEED_I = 16'h0100;
	logic MOVE_DONE_I = 1'b0;
	logic SERVO_READY_O, POS_CLEAR_O, ZERO_HOLD_O, DIR_INVERT_O, MOVE_HOLD_O, MOVE_START_O;
	logic TORQUE_LIMIT_EN_O, SPEED_LIMIT_EN_O;
	logic [1:0] POS_CLEAR_MODE_O, SPEED_SRC_O;
	logic [2:0] MOVE_INDEX_O;
	int n_mismatch = 0, num_checks = 0, cyc = 0;
	logic [7:0] lv = 8'h00, rnd = 8'h03;
	logic slow = 1'b0;
	logic [2:0] exp_q[$];
	logic [31:0] rd;

	always #4 CLK_I = ~CLK_I;

	sdm_ctrl_model ctrl (.clk_i(CLK_I), .level_i(lv), .slow_i(slow), .pins_o(DI_I));
	sdm_top #(.TICK_CYCLES(TICKS)) uut (.CLK_I(CLK_I), .RST_I(RST_I), .ADR_I(ADR_I),
		.DAT_I(DAT_I), .SEL_I(SEL_I), .WE_I(WE_I), .CYC_I(CYC_I), .STB_I(STB_I), .DAT_O(DAT_O),
		.ACK_O(ACK_O), .DI_I(DI_I), .DO_O(DO_O), .FAULT_I(FAULT_I), .BRAKE_REQ_I(BRAKE_REQ_I),
		.HOME_COND_I(HOME_COND_I), .TARGET_SPEED_I(TARGET_SPEED_I),
		.IN_POSITION_I(IN_POSITION_I), .MOTOR_SPEED_I(MOTOR_SPEED_I),
		.MOTOR_LOAD_I(MOTOR_LOAD_I), .MOVE_DONE_I(MOVE_DONE_I), .SERVO_READY_O(SERVO_READY_O),
		.POS_CLEAR_O(POS_CLEAR_O), .POS_CLEAR_MODE_O(POS_CLEAR_MODE_O),
		.ZERO_HOLD_O(ZERO_HOLD_O), .DIR_INVERT_O(DIR_INVERT_O), .MOVE_HOLD_O(MOVE_HOLD_O),
		.MOVE_START_O(MOVE_START_O), .MOVE_INDEX_O(MOVE_INDEX_O),
		.TORQUE_LIMIT_EN_O(TORQUE_LIMIT_EN_O), .SPEED_LIMIT_EN_O(SPEED_LIMIT_EN_O),
		.SPEED_SRC_O(SPEED_SRC_O));
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// One classic bus cycle; the answer is taken at the edge that sees the acknowledge.
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n = 0;
		@(posedge CLK_I);
		CYC_I <= 1'b1;
		STB_I <= 1'b1;
		WE_I <= w;
		ADR_I <= a;
		DAT_I <= d;
		SEL_I <= 4'hF;
		do begin
			@(posedge CLK_I);
			n++;
		end while (ACK_O !== 1'b1 && n < 40);
		if (n >= 40) n_mismatch++;
		rd = DAT_O;
		CYC_I <= 1'b0;
		STB_I <= 1'b0;
		WE_I <= 1'b0;
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		wb(a, 1'b0, 32'h0);
		check(rd, e);
	endtask

	task automatic wt(input int c);
		repeat (c) @(posedge CLK_I);
		#1;
	endtask

	task automatic pin(input int b, input logic v);
		@(posedge CLK_I);
		lv[b] <= v;
		wt(8);
	endtask

	// Raises the trigger pin and counts move starts and pulse clears that follow.
	task automatic trig(output int ns, output int nc);
		ns = 0;
		nc = 0;
		@(posedge CLK_I);
		lv[2] <= 1'b1;
		for (int k = 0; k < 12; k++) begin
			wt(1);
			ns += (MOVE_START_O === 1'b1);
			nc += (POS_CLEAR_O === 1'b1);
			if (MOVE_START_O === 1'b1) check(MOVE_INDEX_O, exp_q.pop_front());
		end
		pin(2, 1'b0);
	endtask

	always @(posedge CLK_I) begin
		cyc++;
		if (cyc > 20000) begin
			n_mismatch++;
			close_out();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		int tw, ta, ns, nc;
		repeat (16) @(posedge CLK_I);
		RST_I <= 1'b0;
		rc(sdm_pkg::OFS_CTRL, sdm_pkg::RST_CTRL);
		rc(sdm_pkg::OFS_DI_MAP0, {sdm_pkg::RST_DI_MAP0[31:8], 2'b00, sdm_pkg::DI_SERVO_ON});
		rc(sdm_pkg::OFS_DI_MAP1, sdm_pkg::RST_DI_MAP1);
		rc(sdm_pkg::OFS_DO_MAP, sdm_pkg::RST_DO_MAP);
		rc(sdm_pkg::OFS_POLARITY, sdm_pkg::RST_POLARITY);
		rc(sdm_pkg::OFS_THRESH, sdm_pkg::RST_THRESH);
		rc(sdm_pkg::OFS_CLR_MASK, sdm_pkg::RST_CLR_MASK);
		rc(8'hFC, 32'h0);
		wb(sdm_pkg::OFS_FAULTS, 1'b1, 32'hFF);
		rc(sdm_pkg::OFS_FAULTS, 32'h0);
		// Pins: servo on, alarm reset, trigger, three position bits, speed bit, hold.
		wb(sdm_pkg::OFS_DI_MAP0, 1'b1, 32'h0B08_0201);
		wb(sdm_pkg::OFS_DI_MAP1, 1'b1, 32'h070E_0D0C);
		wb(sdm_pkg::OFS_DO_MAP, 1'b1, 32'h0830_A2C7);
		wb(sdm_pkg::OFS_CMD_DELAY, 1'b1, 32'h2);
		wb(sdm_pkg::OFS_CTRL, 1'b1, {28'h0, sdm_pkg::MODE_PR});
		rc(sdm_pkg::OFS_DO_MAP, 32'h0830_A2C7);
		pin(0, 1'b1);
		check(SERVO_READY_O, 1'b1);
		rnd = lfsr(rnd);
		for (int i = 0; i < 8; i++) begin
			@(posedge CLK_I);
			lv[5:3] <= i[2:0] ^ rnd[2:0];
			slow <= rnd[i];
			exp_q.push_back(i[2:0] ^ rnd[2:0]);
			wt(6);
			trig(ns, nc);
			check(ns, 1);
		end
		@(posedge CLK_I);
		MOVE_DONE_I <= 1'b1;
		@(posedge CLK_I);
		MOVE_DONE_I <= 1'b0;
		wt(2);
		check(DO_O[3], 1'b0);
		wt(20);
		check(DO_O[3], 1'b1);
		pin(7, 1'b1);
		check(MOVE_HOLD_O, 1'b1);
		pin(7, 1'b0);
		pin(6, 1'b1);
		check(SPEED_SRC_O, 2'b01);
		for (int v = 8'h63; v <= 8'h64; v++) begin
			@(posedge CLK_I);
			MOTOR_LOAD_I <= v[7:0];
			wt(6);
			check(DO_O[2], v == 8'h64);
		end
		@(posedge CLK_I);
		BRAKE_REQ_I <= 1'b1;
		wt(6);
		check(DO_O[4], 1'b1);
		wb(sdm_pkg::OFS_POLARITY, 1'b1, 32'h0001_0000);
		wt(4);
		check(DO_O[0], 1'b1);
		wb(sdm_pkg::OFS_POLARITY, 1'b1, 32'h0);
		// A warning-class fault must show the warning pin before the alarm pin.
		@(posedge CLK_I);
		FAULT_I <= 8'h01;
		tw = 0;
		ta = 0;
		for (int k = 1; k < 10; k++) begin
			wt(1);
			if (DO_O[1] === 1'b1 && tw == 0) tw = k;
			if (DO_O[0] === 1'b1 && ta == 0) ta = k;
		end
		check(tw > 0 && ta > tw, 1'b1);
		check(DO_O[0], 1'b1);
		check(SERVO_READY_O, 1'b0);
		@(posedge CLK_I);
		FAULT_I <= 8'h00;
		pin(1, 1'b1);
		pin(1, 1'b0);
		rc(sdm_pkg::OFS_FAULTS, 32'h0);
		check(DO_O[0], 1'b0);
		wb(sdm_pkg::OFS_CLR_MASK, 1'b1, 32'hFE);
		@(posedge CLK_I);
		FAULT_I <= 8'h01;
		repeat (3) @(posedge CLK_I);
		FAULT_I <= 8'h00;
		pin(1, 1'b1);
		pin(1, 1'b0);
		rc(sdm_pkg::OFS_FAULTS, 32'h1);
		// Trigger pin becomes pulse clear; it acts only in MODE_PT, MODE_PT_S and MODE_PT_T.
		wb(sdm_pkg::OFS_DI_MAP0, 1'b1, 32'h0B04_0201);
		for (int m = 1; m >= 0; m--) begin
			wb(sdm_pkg::OFS_CTRL, 1'b1, m);
			trig(ns, nc);
			check(nc, m == 0);
		end
		// Home sensor, clamp, invert and both limit enables on pins; shared codes on pins 0 and 1.
		wb(sdm_pkg::OFS_DI_MAP0, 1'b1, 32'h1804_0201);
		wb(sdm_pkg::OFS_DI_MAP1, 1'b1, 32'h0A09_0605);
		wb(sdm_pkg::OFS_DO_MAP, 1'b1, 32'h0830_A144);
		@(posedge CLK_I);
		lv[7:3] <= 5'h1F;
		HOME_COND_I <= 1'b1;
		for (int m = 0; m < 11; m++) begin
			@(posedge CLK_I);
			MOTOR_SPEED_I <= 16'h0009 + 16'(m & 1);
			wb(sdm_pkg::OFS_CTRL, 1'b1, 32'(m + ((m & 3) << 4)));
			wt(6);
			check(ZERO_HOLD_O, m[0] == 1'b0);
			check(DIR_INVERT_O, 1'b1);
			check(TORQUE_LIMIT_EN_O, spd_modes[m]);
			check(SPEED_LIMIT_EN_O, trq_modes[m]);
			check(DO_O[0], m < 2);
			check(DO_O[1], brk_modes[m]);
			check(POS_CLEAR_MODE_O, m[1:0]);
		end
		rc(sdm_pkg::OFS_STATUS, 32'h0001_01D4);
		close_out();
	end
endmodule
